// >>> stop_params.svh
/*
  Offsets, field positions, reset values and timing counts of the stop-mode
  entry and release sequencer.
  Assumes an 8-bit register port with a 4-bit word address.
*/
`ifndef STOP_PARAMS_SVH
`define STOP_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_SYS_CTRL_ONE   4'h0
`define OFS_VD_CTRL_TWO    4'h1
`define OFS_WU_CLK_CTRL    4'h2
`define OFS_WU_COUNT       4'h3
`define OFS_KEY_ENABLE     4'h4
`define OFS_KEY_LEVEL      4'h5
`define OFS_STATUS         4'h6

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_STOP_REQ       7
`define BIT_REL_MODE       6
`define BIT_PORT_HOLD      4
`define LSB_REL_SRC        0
`define LSB_VD_ACTION      2
`define LSB_VD_ENABLE      4
`define BIT_WU_SRC_SEL     0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_SYS_CTRL_ONE   8'h00
`define RST_VD_CTRL_TWO    8'h00
`define RST_WU_CLK_CTRL    8'h00
`define RST_WU_COUNT       8'h10
`define RST_KEY_ENABLE     8'h00
`define RST_KEY_LEVEL      8'h00

// ----------------------------------------------------------------
// Source select codes
// ----------------------------------------------------------------
`define SRC_PIN_ONLY       2'h0
`define SRC_VD_ONLY        2'h1
`define SRC_PIN_AND_VD     2'h2

// ----------------------------------------------------------------
// Timing counts and program counter step
// ----------------------------------------------------------------
`define MACHINE_CYCLE_CLKS 4
`define WU_STEP_SHIFT      4
`define PC_STEP            16'h0002

`endif

// >>> stop_pkg.sv
/*
  Types of the stop-mode entry and release sequencer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package stop_pkg;

  // ----------------------------------------------------------------
  // Sequencer states and run modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_STOP  = 2'b01,
    ST_WARM  = 2'b10,
    ST_RESET = 2'b11
  } op_state_t;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_DUAL   = 2'b01,
    MODE_SLOW   = 2'b10,
    MODE_SPARE  = 2'b11
  } run_mode_t;

  // ----------------------------------------------------------------
  // Oscillator and warm-up clock control
  // ----------------------------------------------------------------
  typedef struct packed {
    logic hf_en;
    logic lf_en;
    logic wu_src_hf;
  } clk_ctrl_t;

endpackage : stop_pkg

// >>> sync_two_flop.sv
/*
  Two flip-flop synchroniser for a bundle of independent levels.
  Assumes each bit changes slowly against the clock; no word coherence.
*/
module sync_two_flop #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk_in,
  input  wire logic             srst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  generate
    if (WIDTH < 1) begin : g_chk
      $error("sync_two_flop: WIDTH must be at least 1");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Two stages
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // sync_two_flop

// >>> stop_sequencer.sv
/*
  Stop-mode entry and release sequencer with its control registers.
  Assumes a same-clock register master, asynchronous pins and detectors.
*/
// The register addresses and the plain strobed port were left to the implementer.
// Summary of operation
// - Writing stop bit one enters stop.
// - Stop halts both oscillators and operation.
// - Core state kept; port latch per hold.
// - Entry clears prescaler and divider.
// - Held PC is request address plus two.
// - Resets end stop; warm-up, then single-clock.
// - Pin release only for source 00/10.
// - Level mode releases while pin high.
// - Level mode request with pin high refused.
// - Pin falling during warm-up does nothing.
// - Edge mode releases on pin rise.
// - Edge mode enters even with pin high.
// - Pin rise in first machine cycle ignored.
// - Warm-up clock follows pre-stop main clock.
// - Key at chosen level ends stop.
// - Key returning during warm-up does nothing.
// - Voltage release only for source 01/10.
// - Reset action: drop resets, recovery warms up.
// - Interrupt action: reaching level ends stop.
// - Level reached in first cycle ignored.
// - Warm-up halts core; resume with cleared divider.
// - Non-reset release restores prior mode.
`include "stop_params.svh"

module stop_sequencer
  import stop_pkg::*;
#(
  parameter int KEYS      = 4,
  parameter int PC_W      = 16,
  parameter int BLIND_CLK = `MACHINE_CYCLE_CLKS,
  parameter int WU_SHIFT  = `WU_STEP_SHIFT
) (
  input  wire logic            mclk_in,
  input  wire logic            srst_in,
  input  wire logic [3:0]      reg_addr_in,
  input  wire logic [7:0]      reg_wdata_in,
  input  wire logic            reg_wr_in,
  input  wire logic            reg_rd_in,
  output logic      [7:0]      reg_rdata_out,
  input  wire logic            release_pin_in,
  input  wire logic [KEYS-1:0] key_in,
  input  wire logic [1:0]      vd_above_in,
  input  wire logic            reset_pin_n_in,
  input  wire run_mode_t       cur_mode_in,
  input  wire logic [PC_W-1:0] instr_pc_in,
  output clk_ctrl_t            clk_ctrl_out,
  output logic                 core_halt_out,
  output logic                 tg_clear_out,
  output logic                 port_drive_out,
  output logic                 sys_reset_out,
  output run_mode_t            mode_out,
  output logic                 mode_load_out,
  output logic      [PC_W-1:0] held_pc_out
);

  localparam int WU_W = 8 + WU_SHIFT;
  localparam int SYNC_W = KEYS + 4;

  generate
    if (KEYS < 1 || KEYS > 8) begin : g_chk_keys
      $error("stop_sequencer: KEYS must be 1 to 8");
    end
    if (BLIND_CLK < 1 || BLIND_CLK > 15) begin : g_chk_blind
      $error("stop_sequencer: BLIND_CLK must be 1 to 15");
    end
    if (WU_SHIFT < 0 || WU_SHIFT > 4) begin : g_chk_wu
      $error("stop_sequencer: WU_SHIFT must be 0 to 4");
    end
    if (PC_W < 2 || PC_W > 16) begin : g_chk_pc
      $error("stop_sequencer: PC_W must be 2 to 16");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  op_state_t        state_r;
  op_state_t        state_nxt;
  logic [7:0]       sys1_r;
  logic [7:0]       vdc2_r;
  logic [7:0]       wuc_r;
  logic [7:0]       wucnt_r;
  logic [KEYS-1:0]  key_en_r;
  logic [KEYS-1:0]  key_lvl_r;
  logic [SYNC_W-1:0] sync_w;
  logic             pin_s;
  logic             rst_n_s;
  logic [1:0]       vd_s;
  logic [KEYS-1:0]  key_s;
  logic             pin_d_r;
  logic [1:0]       vd_d_r;
  logic [3:0]       blind_r;
  logic [WU_W-1:0]  wu_cnt_r;
  logic             after_rst_r;
  logic             wu_hf_r;
  logic             wr_sys1;
  logic             stop_req;
  logic             lvl_block;
  logic [1:0]       src;
  logic             pin_ok;
  logic             vd_ok;
  logic             rel_level;
  logic             vd_rst;
  logic             any_rst;
  logic             pin_wake;
  logic             vd_wake;
  logic             key_wake;
  logic             wake;
  logic             entering;
  logic             resuming;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  sync_two_flop #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .mclk_in  (mclk_in),
    .srst_in  (srst_in),
    .async_in ({reset_pin_n_in, vd_above_in, key_in, release_pin_in}),
    .sync_out (sync_w)
  );

  assign pin_s   = sync_w[0];
  assign key_s   = sync_w[KEYS:1];
  assign vd_s    = sync_w[KEYS+2:KEYS+1];
  assign rst_n_s = sync_w[KEYS+3];

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      pin_d_r <= 1'b0;
      vd_d_r  <= 2'h0;
    end else begin
      pin_d_r <= pin_s;
      vd_d_r  <= vd_s;
    end
  end

  // ----------------------------------------------------------------
  // Release conditions
  // ----------------------------------------------------------------
  assign src     = vdc2_r[`LSB_REL_SRC +: 2];
  assign rel_level = sys1_r[`BIT_REL_MODE];
  assign pin_ok  = (src == `SRC_PIN_ONLY) || (src == `SRC_PIN_AND_VD);
  assign vd_ok   = (src == `SRC_VD_ONLY) || (src == `SRC_PIN_AND_VD);
  assign wr_sys1 = reg_wr_in && (reg_addr_in == `OFS_SYS_CTRL_ONE);
  assign stop_req = wr_sys1 && reg_wdata_in[`BIT_STOP_REQ]
                    && (state_r == ST_RUN);
  // Level mode with pin release selected and the pin already high refuses entry
  assign lvl_block = reg_wdata_in[`BIT_REL_MODE] && pin_ok
                     && pin_s;
  assign vd_rst  = |(vdc2_r[`LSB_VD_ENABLE +: 2]
                     & vdc2_r[`LSB_VD_ACTION +: 2] & ~vd_s);
  assign any_rst = vd_rst || !rst_n_s;
  assign pin_wake = pin_ok && (rel_level ? pin_s
                   : (pin_s && !pin_d_r && blind_r == 4'h0));
  assign vd_wake = vd_ok && (blind_r == 4'h0)
                   && |(vdc2_r[`LSB_VD_ENABLE +: 2]
                   & ~vdc2_r[`LSB_VD_ACTION +: 2]
                   & vd_s & ~vd_d_r);
  assign key_wake = |(key_en_r & ~(key_s ^ key_lvl_r));
  assign wake     = pin_wake || vd_wake || key_wake;
  assign entering = stop_req && !lvl_block;
  assign resuming = (state_r == ST_WARM) && (wu_cnt_r == '0);

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    if (any_rst) begin
      state_nxt = ST_RESET;
    end else begin
      unique case (state_r)
        ST_RUN: begin
          if (entering) begin
            state_nxt = ST_STOP;
          end
        end
        ST_STOP: begin
          if (wake) begin
            state_nxt = ST_WARM;
          end
        end
        ST_WARM: begin
          // Pin and key levels are not watched here
          if (resuming) begin
            state_nxt = ST_RUN;
          end
        end
        ST_RESET: begin
          state_nxt = ST_WARM;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      state_r <= ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Entry window and warm-up counting
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      blind_r <= 4'h0;
    end else if (entering) begin
      blind_r <= 4'(BLIND_CLK);
    end else if (blind_r != 4'h0) begin
      blind_r <= blind_r - 4'h1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      wu_cnt_r <= '0;
    end else if (state_nxt == ST_WARM && state_r != ST_WARM) begin
      wu_cnt_r <= WU_W'({wucnt_r, 4'hF} >> (4 - WU_SHIFT));
    end else if (state_r == ST_WARM && wu_cnt_r != '0) begin
      wu_cnt_r <= wu_cnt_r - 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      after_rst_r <= 1'b1;
    end else if (state_r == ST_RESET) begin
      after_rst_r <= 1'b1;
    end else if (entering) begin
      after_rst_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Captured context
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      mode_out    <= MODE_SINGLE;
      wu_hf_r     <= 1'b1;
      held_pc_out <= '0;
    end else if (state_r == ST_RESET) begin
      mode_out <= MODE_SINGLE;
      wu_hf_r  <= 1'b1;
    end else if (entering) begin
      mode_out    <= cur_mode_in;
      wu_hf_r     <= (cur_mode_in != MODE_SLOW);
      held_pc_out <= PC_W'(instr_pc_in + `PC_STEP);
    end
  end

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      clk_ctrl_out   <= '{hf_en: 1'b1, lf_en: 1'b0, wu_src_hf: 1'b1};
      core_halt_out  <= 1'b0;
      tg_clear_out   <= 1'b0;
      port_drive_out <= 1'b1;
      sys_reset_out  <= 1'b0;
      mode_load_out  <= 1'b0;
    end else begin
      unique case (state_nxt)
        ST_RUN: begin
          clk_ctrl_out.hf_en <= (cur_mode_in != MODE_SLOW);
          clk_ctrl_out.lf_en <= (cur_mode_in != MODE_SINGLE);
        end
        ST_STOP: begin
          clk_ctrl_out.hf_en <= 1'b0;
          clk_ctrl_out.lf_en <= 1'b0;
        end
        ST_WARM, ST_RESET: begin
          clk_ctrl_out.hf_en <= (mode_out != MODE_SLOW);
          clk_ctrl_out.lf_en <= (mode_out != MODE_SINGLE);
        end
      endcase
      clk_ctrl_out.wu_src_hf <= wu_hf_r;
      core_halt_out  <= (state_nxt != ST_RUN);
      tg_clear_out   <= (state_nxt != ST_RUN);
      port_drive_out <= (state_nxt != ST_STOP && state_nxt != ST_WARM)
                        || sys1_r[`BIT_PORT_HOLD];
      sys_reset_out  <= (state_nxt == ST_RESET);
      mode_load_out  <= resuming && !any_rst;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      sys1_r <= `RST_SYS_CTRL_ONE;
    end else begin
      if (wr_sys1) begin
        sys1_r <= reg_wdata_in;
        sys1_r[`BIT_STOP_REQ] <= entering;
      end
      if (state_nxt == ST_RUN) begin
        sys1_r[`BIT_STOP_REQ] <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      vdc2_r    <= `RST_VD_CTRL_TWO;
      wuc_r     <= `RST_WU_CLK_CTRL;
      wucnt_r   <= `RST_WU_COUNT;
      key_en_r  <= KEYS'(`RST_KEY_ENABLE);
      key_lvl_r <= KEYS'(`RST_KEY_LEVEL);
    end else if (reg_wr_in) begin
      unique case (reg_addr_in)
        `OFS_VD_CTRL_TWO: vdc2_r    <= {2'h0, reg_wdata_in[5:0]};
        `OFS_WU_CLK_CTRL: wuc_r     <= {7'h00, reg_wdata_in[0]};
        `OFS_WU_COUNT:    wucnt_r   <= reg_wdata_in;
        `OFS_KEY_ENABLE:  key_en_r  <= reg_wdata_in[KEYS-1:0];
        `OFS_KEY_LEVEL:   key_lvl_r <= reg_wdata_in[KEYS-1:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        `OFS_SYS_CTRL_ONE: reg_rdata_out <= sys1_r;
        `OFS_VD_CTRL_TWO:  reg_rdata_out <= vdc2_r;
        `OFS_WU_CLK_CTRL:  reg_rdata_out <= wuc_r;
        `OFS_WU_COUNT:     reg_rdata_out <= wucnt_r;
        `OFS_KEY_ENABLE:   reg_rdata_out <= 8'(key_en_r);
        `OFS_KEY_LEVEL:    reg_rdata_out <= 8'(key_lvl_r);
        `OFS_STATUS: reg_rdata_out <= {state_r, mode_out,
                                       after_rst_r, wu_hf_r, pin_s, 1'b0};
        default:           reg_rdata_out <= 8'h00;
      endcase
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_enter;
    entering && !any_rst;
  endsequence

  sequence s_warm_end;
    resuming && !any_rst;
  endsequence

  property p_enter;
    @(posedge mclk_in) disable iff (srst_in)
      s_enter |=> (state_r == ST_STOP) && sys1_r[`BIT_STOP_REQ];
  endproperty
  a_enter: assert property (p_enter)
    else $error("stop request did not enter stop");

  property p_osc_off;
    @(posedge mclk_in) disable iff (srst_in)
      (state_r == ST_STOP) |-> !clk_ctrl_out.hf_en && !clk_ctrl_out.lf_en
                               && core_halt_out;
  endproperty
  a_osc_off: assert property (p_osc_off)
    else $error("oscillator running in stop");

  property p_tg_clear;
    @(posedge mclk_in) disable iff (srst_in)
      s_enter |=> tg_clear_out [*2];
  endproperty
  a_tg_clear: assert property (p_tg_clear)
    else $error("timing generator not cleared on entry");

  property p_held_pc;
    @(posedge mclk_in) disable iff (srst_in)
      s_enter |=> held_pc_out == PC_W'($past(instr_pc_in) + `PC_STEP);
  endproperty
  a_held_pc: assert property (p_held_pc)
    else $error("held program counter wrong");

  property p_lvl_block;
    @(posedge mclk_in) disable iff (srst_in)
      stop_req && lvl_block && !any_rst |=> (state_r == ST_RUN)
                                          && !sys1_r[`BIT_STOP_REQ];
  endproperty
  a_lvl_block: assert property (p_lvl_block)
    else $error("level mode entered stop with pin high");

  property p_lvl_release;
    @(posedge mclk_in) disable iff (srst_in)
      (state_r == ST_STOP) && rel_level && pin_ok && pin_s && !any_rst
      |=> (state_r == ST_WARM);
  endproperty
  a_lvl_release: assert property (p_lvl_release)
    else $error("level release missed");

  property p_warm_hold;
    @(posedge mclk_in) disable iff (srst_in)
      (state_r == ST_WARM) && !resuming && !any_rst
      |=> (state_r == ST_WARM) && core_halt_out;
  endproperty
  a_warm_hold: assert property (p_warm_hold)
    else $error("warm-up left early");

  property p_blind;
    @(posedge mclk_in) disable iff (srst_in)
      (state_r == ST_STOP) && (blind_r != 4'h0) && !key_wake && !any_rst
      && !(rel_level && pin_ok && pin_s) |=> (state_r == ST_STOP);
  endproperty
  a_blind: assert property (p_blind)
    else $error("release inside entry window");

  property p_reset_path;
    @(posedge mclk_in) disable iff (srst_in)
      (state_r == ST_RESET) && !any_rst
      |=> (state_r == ST_WARM) && (mode_out == MODE_SINGLE) && wu_hf_r;
  endproperty
  a_reset_path: assert property (p_reset_path)
    else $error("reset release did not warm up to single clock");

  property p_resume;
    @(posedge mclk_in) disable iff (srst_in)
      s_warm_end |=> mode_load_out && !core_halt_out && !tg_clear_out
                     && (state_r == ST_RUN);
  endproperty
  a_resume: assert property (p_resume)
    else $error("resume after warm-up wrong");

endmodule // stop_sequencer

// >>> far_side_model.sv
/*
  Far-side model: release pin, key inputs, supply detectors, reset pin.
  Assumes the bench sets requested levels; lines move 13 ns after mclk_in.
*/
module far_side_model #(
  parameter int KEYS = 4
) (
  input  wire logic            mclk_in,
  input  wire logic            pin_req_in,
  input  wire logic [KEYS-1:0] key_req_in,
  input  wire logic [1:0]      vd_req_in,
  input  wire logic            rst_req_in,
  output logic                 release_pin_out,
  output logic      [KEYS-1:0] key_out,
  output logic      [1:0]      vd_above_out,
  output logic                 reset_pin_n_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Lines off the clock edge, as asynchronous pins
  // ----------------------------------------------------------------
  initial begin
    release_pin_out = 1'h0;
    key_out = '0;
    vd_above_out = 2'h3;
    reset_pin_n_out = 1'h1;
  end

  always @(posedge mclk_in) begin
    #13;
    release_pin_out = pin_req_in;
    key_out = key_req_in;
    vd_above_out = vd_req_in;
    reset_pin_n_out = ~rst_req_in;
  end
endmodule // far_side_model

// >>> tb_top.sv
/*
  Self-checking bench of the stop sequencer.
  Assumes stop_pkg, stop_params.svh and far_side_model are compiled first.
*/
`include "stop_params.svh"
module tb_top
  import stop_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk_in = 1'h0, srst_in = 1'h1, reg_wr_in = 1'h0;
  logic        reg_rd_in = 1'h0, rd_d = 1'h0, pin_q = 1'h0, rst_q = 1'h0;
  logic [3:0]  reg_addr_in = 4'h0, key_q = 4'h0, key_in;
  logic [7:0]  reg_wdata_in = 8'h00, reg_rdata_out;
  logic [1:0]  vd_q = 2'h3, vd_above_in;
  logic [15:0] instr_pc_in = 16'h0000, held_pc_out, q[$];
  logic        release_pin_in, reset_pin_n_in, core_halt_out, tg_clear_out;
  logic        port_drive_out, sys_reset_out, mode_load_out, lvl;
  run_mode_t   cur_mode_in = MODE_SINGLE, mode_out, m;
  clk_ctrl_t   clk_ctrl_out;
  int          error_cnt = 0, n_tests = 0, cyc = 0, seed = 32'hccc9, i, k;

  always #25 mclk_in = ~mclk_in;

  stop_sequencer #(.WU_SHIFT(0)) dut (
    .mclk_in, .srst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .release_pin_in, .key_in, .vd_above_in, .reset_pin_n_in,
    .cur_mode_in, .instr_pc_in, .clk_ctrl_out, .core_halt_out, .tg_clear_out,
    .port_drive_out, .sys_reset_out, .mode_out, .mode_load_out, .held_pc_out
  );

  far_side_model far (
    .mclk_in, .pin_req_in(pin_q), .key_req_in(key_q), .vd_req_in(vd_q),
    .rst_req_in(rst_q), .release_pin_out(release_pin_in), .key_out(key_in),
    .vd_above_out(vd_above_in), .reset_pin_n_out(reset_pin_n_in)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task conclude();
    if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input string nm, input logic [15:0] e, s);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask

  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'h1;
    @(posedge mclk_in);
    reg_wr_in <= 1'h0;
  endtask

  task rd(input logic [3:0] a, input logic [7:0] msk, e);
    q.push_back({msk, e});
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'h1;
    @(posedge mclk_in);
    reg_rd_in <= 1'h0;
  endtask

  task enter(input logic [7:0] d, input logic ex, input logic rise);
    logic [15:0] pc;
    m = run_mode_t'({$random(seed)} % 3);
    pc = 16'($random(seed));
    cur_mode_in <= m;
    instr_pc_in <= pc;
    tick(3);
    wr(`OFS_SYS_CTRL_ONE, d);
    if (rise) begin
      pin_q <= 1'h1;
      vd_q[0] <= 1'h1;
    end
    tick(2);
    chk("halt", ex, core_halt_out);
    if (ex) begin
      chk("held_pc", pc + `PC_STEP, held_pc_out);
      chk("tg_clear", 1'h1, tg_clear_out);
      chk("osc", 2'h0, {clk_ctrl_out.hf_en, clk_ctrl_out.lf_en});
      chk("port", d[`BIT_PORT_HOLD], port_drive_out);
    end
  endtask

  task wrel(input run_mode_t em);
    for (i = 0; i < 99 && !(clk_ctrl_out.hf_en | clk_ctrl_out.lf_en); i++)
      tick(1);
    chk("wu_src", em != MODE_SLOW, clk_ctrl_out.wu_src_hf);
    for (i = 0; i < 3000 && mode_load_out !== 1'h1; i++) tick(1);
    chk("load", 1'h1, mode_load_out);
    chk("mode", em, mode_out);
    tick(1);
    chk("halt", 1'h0, core_halt_out);
  endtask

  // ----------------------------------------------------------------
  // Read checker and timeout
  // ----------------------------------------------------------------
  always @(posedge mclk_in) begin
    if (rd_d) begin
      chk("rdata", q[0][7:0], reg_rdata_out & q[0][15:8]);
      void'(q.pop_front());
    end
    rd_d <= reg_rd_in;
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    tick(12);
    srst_in <= 1'h0;
    wrel(MODE_SINGLE);
    wr(4'h7, 8'hFF);
    for (k = 0; k < 8; k++)
      rd(k[3:0], (k == 6) ? 8'hF0 : 8'hFF, (k == 3) ? 8'h10 : 8'h00);
    wr(`OFS_WU_COUNT, 8'h03);
    wr(`OFS_WU_CLK_CTRL, 8'h01);
    rd(`OFS_WU_COUNT, 8'hFF, 8'h03);
    pin_q <= 1'h1;
    enter(8'h80, 1'h1, 1'h0);
    pin_q <= 1'h0;
    tick(6);
    pin_q <= 1'h1;
    wrel(m);
    enter(8'hC0, 1'h0, 1'h0);
    rd(`OFS_SYS_CTRL_ONE, 8'h80, 8'h00);
    pin_q <= 1'h0;
    tick(4);
    enter(8'hD0, 1'h1, 1'h0);
    pin_q <= 1'h1;
    tick(6);
    pin_q <= 1'h0;
    wrel(m);
    for (k = 1; k >= 0; k--) begin
      lvl = k[0];
      wr(`OFS_KEY_ENABLE, 8'h01);
      wr(`OFS_KEY_LEVEL, {7'h00, lvl});
      key_q <= {3'h0, ~lvl};
      pin_q <= 1'h0;
      tick(4);
      enter(8'h80, 1'h1, lvl);
      tick(8);
      chk("halt", 1'h1, core_halt_out);
      key_q[0] <= lvl;
      tick(6);
      key_q[0] <= ~lvl;
      wrel(m);
    end
    wr(`OFS_KEY_ENABLE, 8'h00);
    wr(`OFS_VD_CTRL_TWO, 8'h31);
    vd_q <= 2'h0;
    pin_q <= 1'h0;
    tick(4);
    enter(8'h80, 1'h1, 1'h1);
    pin_q <= 1'h1;
    tick(8);
    chk("halt", 1'h1, core_halt_out);
    vd_q <= 2'h3;
    wrel(m);
    wr(`OFS_VD_CTRL_TWO, 8'h30);
    vd_q <= 2'h0;
    tick(4);
    enter(8'h80, 1'h1, 1'h0);
    vd_q <= 2'h2;
    tick(8);
    chk("halt", 1'h1, core_halt_out);
    pin_q <= 1'h0;
    tick(4);
    pin_q <= 1'h1;
    wrel(m);
    vd_q <= 2'h3;
    tick(4);
    wr(`OFS_VD_CTRL_TWO, 8'h15);
    enter(8'h80, 1'h1, 1'h0);
    vd_q <= 2'h2;
    tick(6);
    chk("sys_reset", 1'h1, sys_reset_out);
    rd(`OFS_STATUS, 8'hC0, 8'hC0);
    vd_q <= 2'h3;
    wrel(MODE_SINGLE);
    enter(8'h80, 1'h1, 1'h0);
    rst_q <= 1'h1;
    tick(6);
    chk("sys_reset", 1'h1, sys_reset_out);
    rst_q <= 1'h0;
    wrel(MODE_SINGLE);
    conclude();
  end
endmodule // tb_top
